// *** include/fcp_pkg.sv ***
// package with command codes, identifier addresses and bus timing counts
package fcp_pkg;
  // command codes
  localparam logic [7:0] CMD_READ_ARRAY   = 8'hFF;
  localparam logic [7:0] CMD_READ_IDENT   = 8'h90;
  localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_ERASE_SETUP  = 8'h20;
  localparam logic [7:0] CMD_CONFIRM      = 8'hD0;
  localparam logic [7:0] CMD_WRITE_SETUP  = 8'h40;
  localparam logic [7:0] CMD_WRITE_ALT    = 8'h10;
  localparam logic [7:0] CMD_SUSPEND      = 8'hB0;
  // identifier word addresses
  localparam logic [18:0] IDENT_MFR_ADDR  = 19'h0_0000;
  localparam logic [18:0] IDENT_DEV_ADDR  = 19'h0_0001;
  // widths
  localparam int ADDR_W = 19;
  localparam int DATA_W = 16;
  // bus phase times in ns, and cycle counts at 250 MHz (rounded up)
  localparam int CLK_PERIOD_PS  = 4000;
  localparam int T_SETUP_NS     = 20;
  localparam int T_STROBE_NS    = 60;
  localparam int T_READ_NS      = 120;
  localparam int T_HOLD_NS      = 20;
  localparam int T_RESET_LOW_NS = 100;
  localparam int SETUP_CYC  = (T_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int STROBE_CYC = (T_STROBE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int READ_CYC   = (T_READ_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int HOLD_CYC   = (T_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RPD_CYC    = (T_RESET_LOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CNT_W      = 8;
  // sequencer operation kinds
  typedef enum logic [3:0] {
    FCP_OP_READ_ARRAY, FCP_OP_READ_IDENT, FCP_OP_READ_STATUS, FCP_OP_CLEAR,
    FCP_OP_ERASE, FCP_OP_WORD_WRITE, FCP_OP_SUSPEND, FCP_OP_RESUME,
    FCP_OP_READ, FCP_OP_POWERDOWN
  } fcp_op_t;
endpackage

// *** include/fcp_cycle_if.sv ***
// interface between the command sequencer and the bus cycle engine
`timescale 1ns/1ps
interface fcp_cycle_if;
  logic                         start;
  logic                         is_write;
  logic [fcp_pkg::ADDR_W-1:0]   addr;
  logic [fcp_pkg::DATA_W-1:0]   wdata;
  logic                         done;
  logic [fcp_pkg::DATA_W-1:0]   rdata;
  logic                         idle;
  modport seq (output start, output is_write, output addr, output wdata,
               input done, input rdata, input idle);
  modport eng (input start, input is_write, input addr, input wdata,
               output done, output rdata, output idle);
endinterface

// *** rtl/fcp_cycle.sv ***
// bus cycle engine: one write or read cycle on the flash pins
`timescale 1ns/1ps
module fcp_cycle (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rst_n,
  // request side
  fcp_cycle_if.eng                cyc,
  // flash pins
  output logic                    ce_n,
  output logic                    oe_n,
  output logic                    we_n,
  output logic [fcp_pkg::ADDR_W-1:0] addr,
  output logic [fcp_pkg::DATA_W-1:0] dq_o,
  output logic                    dq_oe,
  input  wire logic [fcp_pkg::DATA_W-1:0] dq_i
);
  typedef enum logic [2:0] {S_IDLE, S_SETUP, S_STROBE, S_HOLD} fcp_cst_t;
  typedef struct packed {
    fcp_cst_t                      st;
    logic [fcp_pkg::CNT_W-1:0]     cnt;
    logic                          wr;
    logic                          ce_n;
    logic                          oe_n;
    logic                          we_n;
    logic                          dq_oe;
    logic                          done;
    logic [fcp_pkg::ADDR_W-1:0]    addr;
    logic [fcp_pkg::DATA_W-1:0]    wdata;
    logic [fcp_pkg::DATA_W-1:0]    rdata;
  } fcp_cyc_state_t;
  fcp_cyc_state_t s_reg, s_next;
  // synchroniser for returned data: three stages, accepted when two and three agree
  logic [fcp_pkg::DATA_W-1:0] dq_s1_reg, dq_s2_reg, dq_s3_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dq_s1_reg <= 16'h0000;
      dq_s2_reg <= 16'h0000;
      dq_s3_reg <= 16'h0000;
    end else begin
      dq_s1_reg <= dq_i;
      dq_s2_reg <= dq_s1_reg;
      dq_s3_reg <= dq_s2_reg;
    end
  end
  // phase sequencer; oe and we never low together, ce rises at the end of the hold phase after the strobe
  always_comb begin
    s_next      = s_reg;
    s_next.done = 1'b0;
    case (s_reg.st)
      S_IDLE: begin
        if (cyc.start) begin
          s_next.st    = S_SETUP;
          s_next.wr    = cyc.is_write;
          s_next.addr  = cyc.addr;
          s_next.wdata = cyc.wdata;
          s_next.ce_n  = 1'b0;
          s_next.dq_oe = cyc.is_write;
          s_next.cnt   = fcp_pkg::CNT_W'(fcp_pkg::SETUP_CYC);
        end
      end
      S_SETUP: begin
        if (s_reg.cnt <= 8'h01) begin
          s_next.st = S_STROBE;
          if (s_reg.wr) s_next.we_n = 1'b0; // R1
          else s_next.oe_n = 1'b0; // R5
          s_next.cnt = fcp_pkg::CNT_W'(s_reg.wr ? fcp_pkg::STROBE_CYC : fcp_pkg::READ_CYC);
        end else s_next.cnt = s_reg.cnt - 8'h01;
      end
      S_STROBE: begin
        if (s_reg.cnt <= 8'h01) begin
          // write strobe rises first so the device latches on we (R2)
          s_next.st   = S_HOLD;
          s_next.we_n = 1'b1;
          s_next.oe_n = 1'b1; // R12
          if (!s_reg.wr) s_next.rdata = (dq_s2_reg == dq_s3_reg) ? dq_s3_reg : s_reg.rdata;
          s_next.cnt  = fcp_pkg::CNT_W'(fcp_pkg::HOLD_CYC);
        end else s_next.cnt = s_reg.cnt - 8'h01;
      end
      S_HOLD: begin
        if (s_reg.cnt <= 8'h01) begin
          s_next.st    = S_IDLE;
          s_next.ce_n  = 1'b1; // R12
          s_next.dq_oe = 1'b0;
          s_next.done  = 1'b1;
        end else s_next.cnt = s_reg.cnt - 8'h01;
      end
      default: s_next.st = S_IDLE;
    endcase
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg       <= '0;
      s_reg.st    <= S_IDLE;
      s_reg.ce_n  <= 1'b1;
      s_reg.oe_n  <= 1'b1;
      s_reg.we_n  <= 1'b1;
    end else s_reg <= s_next;
  end
  assign ce_n      = s_reg.ce_n;
  assign oe_n      = s_reg.oe_n;
  assign we_n      = s_reg.we_n;
  assign addr      = s_reg.addr;
  assign dq_o      = s_reg.wdata;
  assign dq_oe     = s_reg.dq_oe;
  assign cyc.done  = s_reg.done;
  assign cyc.rdata = s_reg.rdata;
  assign cyc.idle  = (s_reg.st == S_IDLE) && !cyc.start;
endmodule

// *** rtl/fcp_host.sv ***
// host controller that drives the flash command port through its pins
//
// Summary of operation
// (R1) a command is written only with chip select and write strobe both low
// (R2) device latches address and data on the first rising strobe edge
// (R3) commands with no address go out at any address of the device
// (R4) ready_busy_n low means erase or word write is running
// (R5) host never drives output enable and write strobe low together
// (R6) array-read after power-up, power-down exit, or read-array code
// (R7) in array-read mode every read returns array contents
// (R8) read-array is ignored while an operation runs unless suspended
// (R9) identifier reads: address zero maker code, address one device code
// (R10) identifier mode lasts until another valid command is written
// (R11) status-read code makes every later read return status
// (R12) status latched at strobe fall; raise it between reads for fresh status
// (R13) block erase is setup then confirm, both at a block address
// (R14) either word write setup code is accepted
// (R15) second word write cycle carries the target address and data
// (R16) boot blocks alter only with protect high or unlock level on reset
// (R17) host writes only defined command codes
// (R18) erase and word write succeed only with valid programming supply
// (R19) read commands work at any supply level
// (R20) clear-status code clears the sticky error flags
// (R21) error flags stay set until a clear-status command; the flash model also clears them when reset_powerdown_n goes low
// (R22) after erase or word write starts, reads return status
// (R23) confirm code during suspend resumes the operation
// (R24) reset low aborts operation and returns to array-read
`timescale 1ns/1ps
module fcp_host (
  // clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        RESETN,
  // user request: one operation per pulse of REQ_VALID
  input  wire logic        REQ_VALID,
  input  wire fcp_pkg::fcp_op_t REQ_OP,
  input  wire logic [18:0] REQ_ADDR,
  input  wire logic [15:0] REQ_DATA,
  output logic             REQ_READY,
  // user answer
  output logic             RSP_VALID,
  output logic [15:0]      RSP_DATA,
  output logic             DEVICE_BUSY,
  // flash pins
  output logic             CE_N,
  output logic             OE_N,
  output logic             WE_N,
  output logic             RESET_POWERDOWN_N,
  output logic [18:0]      ADDR,
  output logic [15:0]      DATA_BUS_O,
  output logic             DATA_BUS_OE,
  input  wire logic [15:0] DATA_BUS_I,
  input  wire logic        READY_BUSY_N
);
  typedef enum logic [2:0] {H_IDLE, H_CYC1, H_CYC2, H_PD_LOW, H_DONE} fcp_hst_t;
  typedef struct packed {
    fcp_hst_t                  st;
    fcp_pkg::fcp_op_t          op;
    logic [18:0]               addr;
    logic [15:0]               data;
    logic [7:0]                cnt;
    logic                      start;
    logic                      is_write;
    logic [18:0]               c_addr;
    logic [15:0]               c_data;
    logic                      rpd_n;
    logic                      rsp;
    logic [15:0]               rdata;
  } fcp_host_state_t;
  fcp_host_state_t s_reg, s_next;
  logic rst_s1_reg, rst_s2_reg;
  logic rb_s1_reg, rb_s2_reg, rb_s3_reg, busy_reg;
  fcp_cycle_if cyc ();
  // reset release through two flops
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end
  // ready/busy pin through three flops; busy taken once stages two and three agree
  always_ff @(posedge CLK_SYS or negedge rst_s2_reg) begin
    if (!rst_s2_reg) begin
      rb_s1_reg <= 1'b1;
      rb_s2_reg <= 1'b1;
      rb_s3_reg <= 1'b1;
      busy_reg  <= 1'b0;
    end else begin
      rb_s1_reg <= READY_BUSY_N;
      rb_s2_reg <= rb_s1_reg;
      rb_s3_reg <= rb_s2_reg;
      if (rb_s2_reg == rb_s3_reg) busy_reg <= !rb_s3_reg; // R4
    end
  end
  fcp_cycle u_cycle (
    .clk   (CLK_SYS),
    .rst_n (rst_s2_reg),
    .cyc   (cyc.eng),
    .ce_n  (CE_N),
    .oe_n  (OE_N),
    .we_n  (WE_N),
    .addr  (ADDR),
    .dq_o  (DATA_BUS_O),
    .dq_oe (DATA_BUS_OE),
    .dq_i  (DATA_BUS_I)
  );
  assign cyc.start    = s_reg.start;
  assign cyc.is_write = s_reg.is_write;
  assign cyc.addr     = s_reg.c_addr;
  assign cyc.wdata    = s_reg.c_data;
  // command sequencer: maps each operation except power-down onto one or two bus cycles
  always_comb begin
    s_next       = s_reg;
    s_next.start = 1'b0;
    s_next.rsp   = 1'b0;
    case (s_reg.st)
      H_IDLE: begin
        // the pin is released once our own reset is over and stays high between operations
        s_next.rpd_n = 1'b1; // R24
        if (REQ_VALID) begin
          s_next.op       = REQ_OP;
          s_next.addr     = REQ_ADDR;
          s_next.data     = REQ_DATA;
          s_next.c_addr   = REQ_ADDR; // R3
          s_next.is_write = 1'b1; // R1
          s_next.start    = 1'b1;
          s_next.st       = H_CYC1;
          case (REQ_OP)
            fcp_pkg::FCP_OP_READ_ARRAY:  s_next.c_data = {8'h00, fcp_pkg::CMD_READ_ARRAY}; // R6 R8
            fcp_pkg::FCP_OP_READ_IDENT:  s_next.c_data = {8'h00, fcp_pkg::CMD_READ_IDENT}; // R10
            fcp_pkg::FCP_OP_READ_STATUS: s_next.c_data = {8'h00, fcp_pkg::CMD_READ_STATUS}; // R11
            fcp_pkg::FCP_OP_CLEAR:       s_next.c_data = {8'h00, fcp_pkg::CMD_CLEAR_STATUS}; // R20
            fcp_pkg::FCP_OP_ERASE:       s_next.c_data = {8'h00, fcp_pkg::CMD_ERASE_SETUP}; // R13
            fcp_pkg::FCP_OP_WORD_WRITE:  s_next.c_data = {8'h00, fcp_pkg::CMD_WRITE_SETUP}; // R14
            fcp_pkg::FCP_OP_SUSPEND:     s_next.c_data = {8'h00, fcp_pkg::CMD_SUSPEND};
            fcp_pkg::FCP_OP_RESUME:      s_next.c_data = {8'h00, fcp_pkg::CMD_CONFIRM}; // R23
            fcp_pkg::FCP_OP_READ: begin
              s_next.is_write = 1'b0; // R7 R9 R22
              s_next.c_data   = 16'h0000;
            end
            fcp_pkg::FCP_OP_POWERDOWN: begin
              // pulse reset low; the device aborts and returns to array read
              s_next.start = 1'b0;
              s_next.rpd_n = 1'b0; // R24
              s_next.cnt   = 8'(fcp_pkg::RPD_CYC);
              s_next.st    = H_PD_LOW;
            end
            // undefined operation codes are never put on the bus
            default: begin
              s_next.start = 1'b0; // R17
              s_next.st    = H_DONE;
            end
          endcase
        end
      end
      H_CYC1: begin
        if (cyc.done) begin
          if (s_reg.op == fcp_pkg::FCP_OP_ERASE) begin
            s_next.c_addr = s_reg.addr; // R13
            s_next.c_data = {8'h00, fcp_pkg::CMD_CONFIRM};
            s_next.start  = 1'b1;
            s_next.st     = H_CYC2;
          end else if (s_reg.op == fcp_pkg::FCP_OP_WORD_WRITE) begin
            s_next.c_addr = s_reg.addr; // R15
            s_next.c_data = s_reg.data;
            s_next.start  = 1'b1;
            s_next.st     = H_CYC2;
          end else begin
            s_next.rdata = cyc.rdata;
            s_next.st    = H_DONE;
          end
        end
      end
      H_CYC2: if (cyc.done) s_next.st = H_DONE;
      H_PD_LOW: begin
        if (s_reg.cnt <= 8'h01) begin
          s_next.rpd_n = 1'b1;
          s_next.st    = H_DONE;
        end else s_next.cnt = s_reg.cnt - 8'h01;
      end
      H_DONE: begin
        s_next.rsp = 1'b1;
        s_next.st  = H_IDLE;
      end
      default: s_next.st = H_IDLE;
    endcase
  end
  always_ff @(posedge CLK_SYS or negedge rst_s2_reg) begin
    if (!rst_s2_reg) begin
      s_reg       <= '0;
      s_reg.st    <= H_IDLE;
      s_reg.rpd_n <= 1'b0;
    end else begin
      s_reg <= s_next;
    end
  end
  // reset pin straight from a flop: low through our own reset and the power-down pulse
  assign RESET_POWERDOWN_N = s_reg.rpd_n;
  assign REQ_READY   = (s_reg.st == H_IDLE) && cyc.idle;
  assign RSP_VALID   = s_reg.rsp;
  assign RSP_DATA    = s_reg.rdata;
  assign DEVICE_BUSY = busy_reg;
endmodule

// *** verification/fcp_flash_model.sv ***
// behavioural flash device answering the host controller's pins
`timescale 1ns/1ps
module fcp_flash_model #(
  parameter logic [15:0] MFR_CODE = 16'h00A1, // arbitrary value
  parameter logic [15:0] DEV_CODE = 16'h00C3, // arbitrary value
  parameter logic [18:0] BOOT_END = 19'h0_2000, // boot blocks sit below this word address
  parameter int          BUSY_NS  = 1200
) (
  // strobes and reset/power-down
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic        reset_powerdown_n,
  // protection levels: boot-protect input high, programming supply valid
  input  wire logic        boot_unlock,
  input  wire logic        supply_ok,
  // address and data
  input  wire logic [18:0] addr,
  input  wire logic [15:0] din,
  output logic      [15:0] data_bus,
  output logic             ready_busy_n
);
  // =====================================
  // command port state, mode 0 array, 1 ident, 2 status
  logic [1:0]  mode = 2'h0;
  logic [7:0]  pend = 8'h00;
  logic        susp = 1'b0;
  logic [15:0] rd   = 16'h0000;
  logic [6:0]  err  = 7'h00;
  logic [15:0] mem [int];
  time         t_end = 0;
  initial ready_busy_n = 1'b1;
  // capture on whichever strobe rises first while both were low
  always @(posedge we_n or posedge ce_n) begin
    if (reset_powerdown_n && (we_n ^ ce_n)) begin
      if (pend != 8'h00) begin
        // both setup codes mean word write, only the erase needs a confirm
        if ((pend != 8'h20 || din[7:0] == 8'hD0) && (!supply_ok ||
            (!boot_unlock && addr < BOOT_END))) begin
          // refused: sticky error bits only, contents untouched
          err = err | ((pend == 8'h20) ? 7'h20 : 7'h10) | (supply_ok ? 7'h02 : 7'h08);
        end else if (pend != 8'h20 || din[7:0] == 8'hD0) begin
          mem[addr] = (pend != 8'h20) ? din : 16'hFFFF;
          ready_busy_n = 1'b0;
          t_end = $time + BUSY_NS;
        end
        mode = 2'h2;
      end else begin
        case (din[7:0])
          8'hFF: if (ready_busy_n) mode = 2'h0;
          8'h90: mode = 2'h1;
          8'h70: mode = 2'h2;
          8'h50: err = 7'h00;
          8'hB0: if (!ready_busy_n) begin
            susp = 1'b1;
            t_end = t_end - $time;
            ready_busy_n = 1'b1;
            mode = 2'h2;
          end
          8'hD0: if (susp) begin
            susp = 1'b0;
            t_end = t_end + $time;
            ready_busy_n = 1'b0;
            mode = 2'h2;
          end
          default: mode = mode;
        endcase
      end
      pend = (pend == 8'h00 && din[7:0] inside {8'h40, 8'h10, 8'h20}) ? din[7:0] : 8'h00;
    end
  end
  // the operation ends on its own unless suspended
  always #4 begin
    if (!ready_busy_n && !susp && $time >= t_end) ready_busy_n = 1'b1;
  end
  // power-down aborts and falls back to array reads
  always @(negedge reset_powerdown_n) begin
    mode = 2'h0;
    pend = 8'h00;
    susp = 1'b0;
    err  = 7'h00;
    ready_busy_n = 1'b1;
  end
  // output latch loads on the falling select or output enable
  always @(negedge oe_n or negedge ce_n) begin
    if (mode == 2'h2) rd = {8'h00, ready_busy_n, err};
    else if (mode == 2'h1) rd = addr[0] ? DEV_CODE : MFR_CODE;
    else rd = mem.exists(addr) ? mem[addr] : 16'hFFFF;
  end
  // released bus shows the inverse so stale data never looks valid
  assign data_bus = (!ce_n && !oe_n) ? rd : ~rd;
endmodule

// *** verification/fcp_host_asserts.sv ***
// pin-level checks on the host controller
`timescale 1ns/1ps
module fcp_host_asserts (
  // clock and reset
  input wire logic        CLK_SYS,
  input wire logic        RESETN,
  // status toward the user
  input wire logic        DEVICE_BUSY,
  // flash pins
  input wire logic        CE_N,
  input wire logic        OE_N,
  input wire logic        WE_N,
  input wire logic        RESET_POWERDOWN_N,
  input wire logic [18:0] ADDR,
  input wire logic [15:0] DATA_BUS_O,
  input wire logic        DATA_BUS_OE,
  input wire logic        READY_BUSY_N
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);
  // =====================================
  // strobes, power-down pin and busy report
  property p_no_oe_we; !(!OE_N && !WE_N); endproperty
  a_no_oe_we: assert property (p_no_oe_we)
    else $error("output enable and write strobe low together");
  property p_we_sel; !WE_N |-> !CE_N; endproperty
  a_we_sel: assert property (p_we_sel)
    else $error("write strobe without chip select");
  property p_we_drv; $fell(WE_N) |-> DATA_BUS_OE ##1 DATA_BUS_OE; endproperty
  a_we_drv: assert property (p_we_drv)
    else $error("write strobe without driven data");
  property p_we_stable; !WE_N |-> $stable(ADDR) && $stable(DATA_BUS_O); endproperty
  a_we_stable: assert property (p_we_stable)
    else $error("address or data moved under write strobe");
  property p_we_first; $rose(WE_N) |-> !CE_N && DATA_BUS_OE; endproperty
  a_we_first: assert property (p_we_first)
    else $error("write strobe did not rise first");
  property p_oe_nodrv; !OE_N |-> !DATA_BUS_OE && !CE_N; endproperty
  a_oe_nodrv: assert property (p_oe_nodrv)
    else $error("read with host driving or unselected");
  property p_rp_reset; $rose(RESETN) |-> !RESET_POWERDOWN_N; endproperty
  a_rp_reset: assert property (p_rp_reset)
    else $error("power-down pin high at reset release");
  property p_busy; $fell(READY_BUSY_N) |-> ##[1:4] DEVICE_BUSY; endproperty
  a_busy: assert property (p_busy)
    else $error("busy not reported");
  // main scenarios seen
  c_write: cover property ($rose(WE_N));
  c_read: cover property ($rose(OE_N));
  c_busy: cover property ($fell(DEVICE_BUSY));
endmodule
bind fcp_host fcp_host_asserts u_chk (.CLK_SYS(CLK_SYS), .RESETN(RESETN),
  .DEVICE_BUSY(DEVICE_BUSY), .CE_N(CE_N), .OE_N(OE_N), .WE_N(WE_N),
  .RESET_POWERDOWN_N(RESET_POWERDOWN_N), .ADDR(ADDR), .DATA_BUS_O(DATA_BUS_O),
  .DATA_BUS_OE(DATA_BUS_OE), .READY_BUSY_N(READY_BUSY_N));

// *** verification/tb_top.sv ***
// self-checking bench: host controller against a behavioural flash
`timescale 1ns/1ps
module tb_top;
  // =====================================
  // wires, clock and counters
  localparam logic [15:0] MFR = 16'h00A1; // arbitrary value
  localparam logic [15:0] DEV = 16'h00C3; // arbitrary value
  localparam logic [18:0] WA  = 19'h1_2345;
  localparam logic [18:0] BA  = 19'h0_0100; // inside a boot block
  logic             boot_unlock = 1'b1;
  logic             supply_ok = 1'b1;
  logic             clk = 1'b0;
  logic             resetn = 1'b0;
  logic             req_valid = 1'b0;
  fcp_pkg::fcp_op_t req_op = fcp_pkg::FCP_OP_READ;
  logic [18:0]      req_addr = 19'h0_0000;
  logic [15:0]      req_data = 16'h0000;
  logic             req_ready, rsp_valid, dev_busy, ce_n, oe_n, we_n, rp_n, dq_oe, rb_n;
  logic [15:0]      rsp_data, dq_o, dq_i;
  logic [18:0]      addr;
  int               fails = 0;
  int               comparisons = 0;
  initial forever #2 clk = ~clk;
  fcp_host dut (.CLK_SYS(clk), .RESETN(resetn), .REQ_VALID(req_valid), .REQ_OP(req_op),
    .REQ_ADDR(req_addr), .REQ_DATA(req_data), .REQ_READY(req_ready), .RSP_VALID(rsp_valid),
    .RSP_DATA(rsp_data), .DEVICE_BUSY(dev_busy), .CE_N(ce_n), .OE_N(oe_n), .WE_N(we_n),
    .RESET_POWERDOWN_N(rp_n), .ADDR(addr), .DATA_BUS_O(dq_o), .DATA_BUS_OE(dq_oe),
    .DATA_BUS_I(dq_i), .READY_BUSY_N(rb_n));
  fcp_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) u_flash (.ce_n(ce_n), .oe_n(oe_n),
    .we_n(we_n), .reset_powerdown_n(rp_n), .boot_unlock(boot_unlock), .supply_ok(supply_ok),
    .addr(addr), .din(dq_o), .data_bus(dq_i),
    .ready_busy_n(rb_n));
  // =====================================
  // shared tasks
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one request, then a bounded wait for its answer pulse
  task automatic op(input fcp_pkg::fcp_op_t o, input logic [18:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(negedge clk);
    while (req_ready !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    req_op = o;
    req_addr = a;
    req_data = d;
    req_valid = 1'b1;
    @(negedge clk);
    req_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    check({15'h0000, rsp_valid}, 16'h0001);
  endtask
  task automatic rd(input logic [18:0] a, input logic [15:0] exp);
    op(fcp_pkg::FCP_OP_READ, a, 16'h0000);
    check(rsp_data, exp);
  endtask
  task automatic wait_busy(input logic v);
    int n;
    n = 0;
    while (dev_busy !== v && n < 1000) begin
      @(negedge clk);
      n++;
    end
    check({15'h0000, dev_busy}, {15'h0000, v});
  endtask
  // =====================================
  // scenarios
  task automatic t_reset();
    check({11'h000, ce_n, oe_n, we_n, rp_n, dq_oe}, 16'h001C);
    $display("reset test done");
  endtask
  task automatic t_ident();
    op(fcp_pkg::FCP_OP_READ_IDENT, WA, 16'h0000);
    rd(19'h0_0000, MFR);
    rd(19'h0_0001, DEV);
    rd(19'h0_0000, MFR);
    $display("ident test done");
  endtask
  task automatic t_write();
    op(fcp_pkg::FCP_OP_WORD_WRITE, WA, 16'hBEEF);
    op(fcp_pkg::FCP_OP_READ_ARRAY, WA, 16'h0000);
    rd(WA, 16'h0000);
    check({15'h0000, dev_busy}, 16'h0001);
    wait_busy(1'b0);
    rd(WA, 16'h0080);
    op(fcp_pkg::FCP_OP_READ_ARRAY, WA, 16'h0000);
    rd(WA, 16'hBEEF);
    $display("word write test done");
  endtask
  task automatic t_erase();
    op(fcp_pkg::FCP_OP_ERASE, WA, 16'h0000);
    wait_busy(1'b1);
    op(fcp_pkg::FCP_OP_SUSPEND, WA, 16'h0000);
    wait_busy(1'b0);
    rd(WA, 16'h0080);
    op(fcp_pkg::FCP_OP_READ_ARRAY, WA, 16'h0000);
    rd(19'h0_0007, 16'hFFFF);
    op(fcp_pkg::FCP_OP_RESUME, WA, 16'h0000);
    wait_busy(1'b1);
    wait_busy(1'b0);
    op(fcp_pkg::FCP_OP_CLEAR, WA, 16'h0000);
    op(fcp_pkg::FCP_OP_READ_STATUS, WA, 16'h0000);
    rd(WA, 16'h0080);
    op(fcp_pkg::FCP_OP_READ_ARRAY, WA, 16'h0000);
    rd(WA, 16'hFFFF);
    $display("erase test done");
  endtask
  // refused alterations leave contents alone and raise sticky error bits
  task automatic t_protect();
    supply_ok = 1'b0;
    op(fcp_pkg::FCP_OP_WORD_WRITE, WA, 16'h1234);
    rd(WA, 16'h0098);
    supply_ok = 1'b1;
    boot_unlock = 1'b0;
    op(fcp_pkg::FCP_OP_ERASE, BA, 16'h0000);
    rd(BA, 16'h00BA);
    boot_unlock = 1'b1;
    op(fcp_pkg::FCP_OP_CLEAR, WA, 16'h0000);
    rd(WA, 16'h0080);
    op(fcp_pkg::FCP_OP_READ_ARRAY, WA, 16'h0000);
    rd(WA, 16'hFFFF);
    $display("protection test done");
  endtask
  task automatic t_powerdown();
    op(fcp_pkg::FCP_OP_READ_IDENT, WA, 16'h0000);
    op(fcp_pkg::FCP_OP_POWERDOWN, WA, 16'h0000);
    rd(19'h0_0000, 16'hFFFF);
    $display("power-down test done");
  endtask
  task automatic results();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // =====================================
  // main sequence and watchdog
  initial begin
    repeat (8) @(negedge clk);
    t_reset();
    resetn = 1'b1;
    repeat (3) @(negedge clk);
    t_ident();
    t_write();
    t_erase();
    t_protect();
    t_powerdown();
    results();
  end
  initial begin
    #100000;
    fails++;
    $display("ERROR %0t: watchdog expired", $time);
    results();
  end
endmodule
